// ==== verilog/tob_pkg.sv ====
/*
 Constants for the trim option bank: register addresses, trim location map,
 field positions and reset values.
 Assumes a byte-wide register port on the system clock.
*/
package tob_pkg;

   // =====================================================================
   // Register port addresses
   localparam logic [11:0] TOB_ADDR_SELECT = 12'hff6;
   localparam logic [11:0] TOB_ADDR_VALUE  = 12'hff7;

   // =====================================================================
   // Trim location map
   localparam int          TOB_LOC_COUNT   = 9;
   localparam int          TOB_MEM_DEPTH   = 32;
   localparam logic [7:0]  TOB_INFO_BASE   = 8'h20;
   localparam logic [4:0]  TOB_LOC_TEMP_LO = 5'h00;
   localparam logic [4:0]  TOB_LOC_TEMP_HI = 5'h01;
   localparam logic [4:0]  TOB_LOC_OSC     = 5'h02;
   localparam logic [4:0]  TOB_LOC_VOLT    = 5'h03;
   localparam logic [4:0]  TOB_LOC_ADC     = 5'h04;
   localparam logic [4:0]  TOB_LOC_VREF    = 5'h05;
   localparam logic [4:0]  TOB_LOC_XTAL    = 5'h06;
   localparam logic [4:0]  TOB_LOC_RSV0    = 5'h07;
   localparam logic [4:0]  TOB_LOC_RSV1    = 5'h08;

   // =====================================================================
   // Field positions
   localparam int          TOB_FINE_LSB    = 4;
   localparam int          TOB_RSV_BIT     = 3;
   localparam int          TOB_NEG_LSB     = 4;
   localparam int          TOB_BROWN_LSB   = 4;

   // =====================================================================
   // Reset values
   localparam logic [7:0]  TOB_TEMP_LO_RST = 8'h83;
   localparam logic [7:0]  TOB_TEMP_HI_RST = 8'ha6;
   localparam logic [7:0]  TOB_SELECT_RST  = 8'h00;
   localparam logic [7:0]  TOB_VALUE_RST   = 8'h00;

   // Threshold in millivolts: base minus step per count
   localparam logic [11:0] TOB_LVD_BASE_MV = 12'h0c80;
   localparam logic [11:0] TOB_LVD_STEP_MV = 12'h0032;

endpackage : tob_pkg

// ==== verilog/tob_mem.sv ====
/*
 Byte store for the information page trim area.
 Not reset: contents survive system reset. Registered read data.
*/
module tob_mem #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // Clock
   input  wire logic          clk_i,
   input  wire logic          ce_i,
   // Write port
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [7:0]    wdata_i,
   // Read port
   input  wire logic [AW-1:0] raddr_i,
   output logic      [7:0]    rdata_o
);

   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (we_i) begin
            mem[waddr_i] <= wdata_i;
         end
         rdata_o <= mem[raddr_i];
      end
   end

endmodule : tob_mem

// ==== verilog/tob_bank.sv ====
/*
 Trim option bank: indirect select and value registers in front of the
 information page trim bytes, with decoded trim fields driven out.
 Assumes a synchronous byte register port on CLK_I; no pin inputs.
*/
// Summary of operation
// - Nine trim locations are decoded: two temperature, oscillator, voltage, ADC, reference, crystal and two reserved.
// - Location 0 sits at page byte 20h with fine offset in bits 7:4 and finest offset in bits 2:0.
// - Location 1 sits at page byte 21h with negative offset in bits 7:4 and rough offset in bits 3:0.
// - Location 2 at page byte 22h is a whole byte driving the oscillator trim inputs.
// - The detect threshold is 3.2 V less 50 mV per count of the code.
// - All trim bytes read and write, and the trim store keeps its contents through reset.
// - Writing the select register at FF6h picks the trim location for later value accesses.
// - The value register at FF7h reads or writes the byte of the selected location.
// - Location numbers 00h to 1Fh map to page bytes 20h to 3Fh by adding 20h.
module tob_bank (
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic        CE_I,
   // Register port
   input  wire logic [11:0] ADDR_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   input  wire logic [7:0]  WDATA_I,
   output logic      [7:0]  RDATA_O,
   // Decoded trim fields
   output logic      [3:0]  TEMP_OFFSET_FINE_O,
   output logic      [2:0]  TEMP_OFFSET_FINEST_O,
   output logic      [3:0]  TEMP_OFFSET_NEGATIVE_O,
   output logic      [3:0]  TEMP_OFFSET_ROUGH_O,
   output logic      [7:0]  OSC_TRIM_BYTE_O,
   output logic      [3:0]  BROWNOUT_NIBBLE_RESERVED_O,
   output logic      [3:0]  DETECT_THRESHOLD_CODE_O,
   output logic      [11:0] DETECT_THRESHOLD_MV_O,
   output logic      [7:0]  ADC_TRIM_O,
   output logic      [7:0]  VREF_TRIM_O,
   output logic      [7:0]  XTAL_TRIM_O,
   output logic             SELECT_DECODED_O
);

   // ==================================================================
   // State
   typedef struct packed {
      logic [7:0] trim_select_reg;
      logic [7:0] trim_value_reg;
      logic [7:0] shadow_lo;
      logic [7:0] shadow_hi;
      logic [7:0] shadow_osc;
      logic [7:0] shadow_volt;
      logic [7:0] shadow_adc;
      logic [7:0] shadow_vref;
      logic [7:0] shadow_xtal;
   } tob_state_t;

   tob_state_t st_reg;
   tob_state_t st_next;

   // ==================================================================
   // Decode helpers
   function automatic logic tob_is_known(input logic [7:0] sel);
      tob_is_known = (sel < 8'(tob_pkg::TOB_LOC_COUNT));
   endfunction : tob_is_known

   function automatic logic [7:0] tob_page_addr(input logic [7:0] sel);
      tob_page_addr = tob_pkg::TOB_INFO_BASE + {3'h0, sel[4:0]};
   endfunction : tob_page_addr

   logic       sel_wr;
   logic       val_wr;
   logic [4:0] mem_raddr;
   logic [7:0] mem_rdata;
   logic       val_wr_d;

   assign sel_wr = WR_I && (ADDR_I == tob_pkg::TOB_ADDR_SELECT);
   assign val_wr = WR_I && (ADDR_I == tob_pkg::TOB_ADDR_VALUE);

   // Read address follows the new select in the write cycle so the next
   // cycle already holds the right byte
   assign mem_raddr = sel_wr ? WDATA_I[4:0] : st_reg.trim_select_reg[4:0];

   // ==================================================================
   // Trim store, not reset
   tob_mem #(
      .DEPTH (tob_pkg::TOB_MEM_DEPTH),
      .AW    (5)
   ) u_mem (
      .clk_i   (CLK_I),
      .ce_i    (CE_I),
      .we_i    (val_wr),
      .waddr_i (st_reg.trim_select_reg[4:0]),
      .wdata_i (WDATA_I),
      .raddr_i (mem_raddr),
      .rdata_o (mem_rdata)
   );

   // ==================================================================
   // Next state
   always_comb begin
      logic [4:0] loc;
      loc = st_reg.trim_select_reg[4:0];
      st_next = st_reg;
      if (sel_wr) begin
         st_next.trim_select_reg = WDATA_I;
      end
      if (val_wr) begin
         st_next.trim_value_reg = WDATA_I;
         if (st_reg.trim_select_reg[7:5] == 3'h0) begin
            case (loc)
               tob_pkg::TOB_LOC_TEMP_LO: st_next.shadow_lo   = WDATA_I;
               tob_pkg::TOB_LOC_TEMP_HI: st_next.shadow_hi   = WDATA_I;
               tob_pkg::TOB_LOC_OSC:     st_next.shadow_osc  = WDATA_I;
               tob_pkg::TOB_LOC_VOLT:    st_next.shadow_volt = WDATA_I;
               tob_pkg::TOB_LOC_ADC:     st_next.shadow_adc  = WDATA_I;
               tob_pkg::TOB_LOC_VREF:    st_next.shadow_vref = WDATA_I;
               tob_pkg::TOB_LOC_XTAL:    st_next.shadow_xtal = WDATA_I;
               default: ;
            endcase
         end
      end
   end

   // Shadow bytes carry reset values only where the map gives one; the
   // rest come up zero until software loads them
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_reg                 <= '0;
         st_reg.trim_select_reg <= tob_pkg::TOB_SELECT_RST;
         st_reg.trim_value_reg  <= tob_pkg::TOB_VALUE_RST;
         st_reg.shadow_lo       <= tob_pkg::TOB_TEMP_LO_RST;
         st_reg.shadow_hi       <= tob_pkg::TOB_TEMP_HI_RST;
      end else if (CE_I) begin
         st_reg <= st_next;
      end
   end

   // ==================================================================
   // Read data, registered
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= 8'h00;
         val_wr_d <= 1'b0;
      end else if (CE_I) begin
         val_wr_d <= val_wr;
         if (RD_I && ADDR_I == tob_pkg::TOB_ADDR_SELECT) begin
            RDATA_O <= st_reg.trim_select_reg;
         end else if (RD_I && ADDR_I == tob_pkg::TOB_ADDR_VALUE) begin
            // Store read data lags a value write by one cycle, so bypass it
            RDATA_O <= val_wr_d ? st_reg.trim_value_reg : mem_rdata;
         end else if (RD_I) begin
            RDATA_O <= 8'h00;
         end
      end
   end

   // ==================================================================
   // Field outputs from the shadow bytes; select decode from the select register
   always_comb begin
      TEMP_OFFSET_FINE_O     = st_reg.shadow_lo[7:tob_pkg::TOB_FINE_LSB];
      TEMP_OFFSET_FINEST_O   = st_reg.shadow_lo[2:0];
      TEMP_OFFSET_NEGATIVE_O = st_reg.shadow_hi[7:tob_pkg::TOB_NEG_LSB];
      TEMP_OFFSET_ROUGH_O    = st_reg.shadow_hi[3:0];
      OSC_TRIM_BYTE_O        = st_reg.shadow_osc;
      BROWNOUT_NIBBLE_RESERVED_O = st_reg.shadow_volt[7:tob_pkg::TOB_BROWN_LSB];
      DETECT_THRESHOLD_CODE_O    = st_reg.shadow_volt[3:0];
      DETECT_THRESHOLD_MV_O  = tob_pkg::TOB_LVD_BASE_MV
                             - 12'(st_reg.shadow_volt[3:0] * tob_pkg::TOB_LVD_STEP_MV);
      ADC_TRIM_O             = st_reg.shadow_adc;
      VREF_TRIM_O            = st_reg.shadow_vref;
      XTAL_TRIM_O            = st_reg.shadow_xtal;
      SELECT_DECODED_O       = tob_is_known(st_reg.trim_select_reg)
                             && (tob_page_addr(st_reg.trim_select_reg) >= tob_pkg::TOB_INFO_BASE);
   end

endmodule : tob_bank

// ==== testbench/tob_bank_assertions.sv ====
/*
 Checker for the trim option bank register port and trim field outputs.
 Assumes it is bound onto tob_bank and sees only that module's ports.
*/
module tob_chk (
   // Clock, reset, register port
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic        CE_I,
   input wire logic [11:0] ADDR_I,
   input wire logic        WR_I,
   input wire logic        RD_I,
   input wire logic [7:0]  WDATA_I,
   input wire logic [7:0]  RDATA_O,
   // Trim fields
   input wire logic [3:0]  TEMP_OFFSET_FINE_O,
   input wire logic [2:0]  TEMP_OFFSET_FINEST_O,
   input wire logic [3:0]  TEMP_OFFSET_NEGATIVE_O,
   input wire logic [3:0]  TEMP_OFFSET_ROUGH_O,
   input wire logic [7:0]  OSC_TRIM_BYTE_O,
   input wire logic [3:0]  DETECT_THRESHOLD_CODE_O,
   input wire logic [11:0] DETECT_THRESHOLD_MV_O,
   input wire logic        SELECT_DECODED_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sel_reg;
   logic [7:0] wd_reg;
   logic       wsel;
   logic       wval;
   logic       rsel;
   assign wsel = CE_I && WR_I && ADDR_I == tob_pkg::TOB_ADDR_SELECT;
   assign wval = CE_I && WR_I && ADDR_I == tob_pkg::TOB_ADDR_VALUE;
   assign rsel = CE_I && RD_I && !WR_I && ADDR_I == tob_pkg::TOB_ADDR_SELECT;
   // Shadow select, to know where a value write lands
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sel_reg <= 8'h00;
         wd_reg  <= 8'h00;
      end else begin
         wd_reg <= WDATA_I;
         if (wsel) begin
            sel_reg <= WDATA_I;
         end
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_select_read_back: assert property (rsel |=> RDATA_O == sel_reg)
      else $error("select read mismatch");
   a_loc0_fields: assert property (wval && sel_reg == 8'h00 |=>
      TEMP_OFFSET_FINE_O == wd_reg[7:4] && TEMP_OFFSET_FINEST_O == wd_reg[2:0])
      else $error("location 0 fields wrong");
   a_loc1_fields: assert property (wval && sel_reg == 8'h01 |=>
      TEMP_OFFSET_NEGATIVE_O == wd_reg[7:4] && TEMP_OFFSET_ROUGH_O == wd_reg[3:0])
      else $error("location 1 fields wrong");
   a_osc_byte: assert property (wval && sel_reg == 8'h02 |=> OSC_TRIM_BYTE_O == wd_reg)
      else $error("oscillator byte wrong");
   a_code_field: assert property (wval && sel_reg == 8'h03 |=>
      DETECT_THRESHOLD_CODE_O == wd_reg[3:0]) else $error("threshold code wrong");
   a_threshold_mv: assert property (DETECT_THRESHOLD_MV_O ==
      12'h0c80 - 12'h0032 * {8'h00, DETECT_THRESHOLD_CODE_O}) else $error("threshold wrong");
   a_reset_fields: assert property ($fell(RST_I) |-> RDATA_O == 8'h00 &&
      {TEMP_OFFSET_FINE_O, 1'b0, TEMP_OFFSET_FINEST_O} == 8'h83 &&
      {TEMP_OFFSET_NEGATIVE_O, TEMP_OFFSET_ROUGH_O} == 8'ha6) else $error("reset values wrong");
   a_rdata_holds: assert property (!(CE_I && RD_I) |=> $stable(RDATA_O))
      else $error("read data moved without a read");
   a_decode_range: assert property (SELECT_DECODED_O == (sel_reg <= 8'h08))
      else $error("select decode wrong");
   cover property (wsel ##1 CE_I && RD_I);
   cover property (wval && sel_reg == 8'h03);
   cover property ($fell(RST_I));
endmodule : tob_chk

// ==== testbench/tb.sv ====
/*
 Self-checking bench for the trim option bank.
 Assumes the package, the design and the checker are compiled before it.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] SEL_A = tob_pkg::TOB_ADDR_SELECT;
   localparam logic [11:0] VAL_A = tob_pkg::TOB_ADDR_VALUE;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [11:0] addr = 12'h0000;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata, osc, adc, vref, xtal;
   logic [3:0]  fine, neg, rough, brown, code;
   logic [2:0]  finest;
   logic [11:0] mv;
   logic        dec;
   int          bad_count = 0;
   int          comparisons = 0;
   // Bit 3 of location 0 kept at one, upper nibble of location 3 zero
   logic [7:0]  pat [9] = '{8'h5a, 8'h3c, 8'hc7, 8'h09, 8'h91, 8'hff, 8'h4e, 8'h12, 8'h34};
   always #4 clk = ~clk;
   tob_bank i_tob_bank (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr), .WR_I(wr),
      .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata), .TEMP_OFFSET_FINE_O(fine),
      .TEMP_OFFSET_FINEST_O(finest), .TEMP_OFFSET_NEGATIVE_O(neg), .TEMP_OFFSET_ROUGH_O(rough),
      .OSC_TRIM_BYTE_O(osc), .BROWNOUT_NIBBLE_RESERVED_O(brown), .DETECT_THRESHOLD_CODE_O(code),
      .DETECT_THRESHOLD_MV_O(mv), .ADC_TRIM_O(adc), .VREF_TRIM_O(vref), .XTAL_TRIM_O(xtal),
      .SELECT_DECODED_O(dec));
   // =====================================================================
   // Access tasks
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Strobes set once per falling edge, so back-to-back calls never glitch
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(negedge clk);
   endtask : acc
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(what, {4'h0, exp}, {4'h0, rdata});
   endtask : rd_chk
   task automatic tally_and_finish();
      $display("TB: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // =====================================================================
   // Tests
   initial begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk("loc0 out", 12'h083, {4'h0, fine, 1'b0, finest});
      chk("loc1 out", 12'h0a6, {4'h0, neg, rough});
      rd_chk("select", SEL_A, 8'h00);
      $display("test reset_state done");
      for (int i = 0; i < 9; i++) begin
         acc(1'b1, SEL_A, 8'(i));
         acc(1'b1, VAL_A, pat[i]);
         chk("decoded", 12'h001, {11'h000, dec});
      end
      acc(1'b1, SEL_A, 8'h1f);
      acc(1'b1, VAL_A, 8'h77);
      rd_chk("loc 1f", VAL_A, 8'h77);
      for (int i = 0; i < 9; i++) begin
         acc(1'b1, SEL_A, 8'(i));
         rd_chk("loc", VAL_A, pat[i]);
      end
      chk("loc0 out", {4'h0, pat[0][7:4], 1'b0, pat[0][2:0]}, {4'h0, fine, 1'b0, finest});
      chk("loc1 out", {4'h0, pat[1]}, {4'h0, neg, rough});
      chk("osc", {4'h0, pat[2]}, {4'h0, osc});
      chk("adc", {4'h0, pat[4]}, {4'h0, adc});
      chk("vref", {4'h0, pat[5]}, {4'h0, vref});
      chk("xtal", {4'h0, pat[6]}, {4'h0, xtal});
      $display("test location_map done");
      acc(1'b1, SEL_A, 8'h20);
      rd_chk("select 8 bit", SEL_A, 8'h20);
      chk("decoded", 12'h000, {11'h000, dec});
      ce = 1'b0;
      acc(1'b1, SEL_A, 8'h02);
      ce = 1'b1;
      rd_chk("frozen select", SEL_A, 8'h20);
      rd_chk("unmapped", 12'h0100, 8'h00);
      $display("test select_edges done");
      acc(1'b1, SEL_A, 8'h03);
      for (int c = 0; c < 16; c++) begin
         acc(1'b1, VAL_A, {4'h0, c[3:0]});
         chk("code", {8'h00, c[3:0]}, {8'h00, code});
         chk("brown", 12'h000, {8'h00, brown});
         chk("mv", 12'h0c80 - 12'h0032 * 12'(c), mv);
      end
      $display("test threshold done");
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk("rdata", 12'h000, {4'h0, rdata});
      chk("loc0 out", 12'h083, {4'h0, fine, 1'b0, finest});
      chk("osc", 12'h000, {4'h0, osc});
      acc(1'b1, SEL_A, 8'h02);
      rd_chk("kept", VAL_A, pat[2]);
      acc(1'b0, 12'h0000, 8'h00);
      $display("test retention done");
      tally_and_finish();
   end
endmodule : tb
bind tob_bank tob_chk i_tob_chk (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
   .WR_I(WR_I), .RD_I(RD_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
   .TEMP_OFFSET_FINE_O(TEMP_OFFSET_FINE_O), .TEMP_OFFSET_FINEST_O(TEMP_OFFSET_FINEST_O),
   .TEMP_OFFSET_NEGATIVE_O(TEMP_OFFSET_NEGATIVE_O), .TEMP_OFFSET_ROUGH_O(TEMP_OFFSET_ROUGH_O),
   .OSC_TRIM_BYTE_O(OSC_TRIM_BYTE_O), .DETECT_THRESHOLD_CODE_O(DETECT_THRESHOLD_CODE_O),
   .DETECT_THRESHOLD_MV_O(DETECT_THRESHOLD_MV_O), .SELECT_DECODED_O(SELECT_DECODED_O));
